//--- pkg/rxq_pkg.sv
// constants, register map and state codes of the receive descriptor queue engine
package rxq_pkg;

    // ========================================================================
    // register offsets
    localparam logic [7:0] OFF_CQ1_CTRL  = 8'hbc;
    localparam logic [7:0] OFF_CQ2_CTRL  = 8'hc0;
    localparam logic [7:0] OFF_CQ1_CONS  = 8'hc4;
    localparam logic [7:0] OFF_CQ1_PROD  = 8'hc8;
    localparam logic [7:0] OFF_CQ2_PTRS  = 8'hcc;
    localparam logic [7:0] OFF_DMA_CTRL  = 8'hd0;
    localparam logic [7:0] OFF_BQ1_CTRL  = 8'hd4;
    localparam logic [7:0] OFF_BQ2_CTRL  = 8'hd8;
    localparam logic [7:0] OFF_BQ1_BASE  = 8'he0;
    localparam logic [7:0] OFF_BQ2_BASE  = 8'he4;
    localparam logic [7:0] OFF_BQ1_PTRS  = 8'he8;
    localparam logic [7:0] OFF_BQ2_PTRS  = 8'hec;

    // ========================================================================
    // field layouts
    localparam int          CQ_FMT_LSB     = 0;
    localparam logic [31:0] CQ_BASE_MASK   = 32'hffff_ff00;
    localparam int          DMA_CQ2_EN_BIT = 0;
    localparam int          DMA_SORT_LSB   = 1;
    localparam int          BQ_LEN_LSB     = 0;
    localparam int          BQ_POLL_BIT    = 16;
    localparam int          BQ_DEPTH_BIT   = 17;
    localparam int          BQ_WIDE_BIT    = 18;
    localparam int          BQ2_EN_BIT     = 16;
    localparam int          PTR_PROD_LSB   = 0;
    localparam int          PTR_CONS_LSB   = 16;
    localparam int          DESC_VALID_BIT = 0;
    localparam int          DESC_END_BIT   = 1;
    localparam logic [31:0] DESC_ADDR_MASK = 32'hffff_fffc;
    localparam logic [31:0] REG_RESET      = 32'h0000_0000;

    // ========================================================================
    // ring depths and index widths
    localparam int          BQ_IDX_W       = 11;
    localparam int          CQ_IDX_W       = 10;
    localparam logic [10:0] BQ_LAST_SMALL  = 11'h0ff;   // 256 entries
    localparam logic [10:0] BQ_LAST_LARGE  = 11'h7ff;   // 2048 entries
    localparam logic [9:0]  CQ_LAST        = 10'h3ff;   // 1024 entries
    localparam logic [2:0]  WORD_SHIFT     = 3'h2;      // 4-byte words

    // ========================================================================
    // completion formats and sort criteria
    localparam logic [1:0]  FMT_SHORT      = 2'h0;
    localparam logic [1:0]  FMT_BASIC      = 2'h1;
    localparam logic [1:0]  FMT_CSUM       = 2'h2;
    localparam logic [1:0]  FMT_FULL       = 2'h3;
    localparam logic [1:0]  SORT_FILTER    = 2'h0;
    localparam logic [1:0]  SORT_VLAN      = 2'h1;
    localparam logic [1:0]  SORT_SIZE      = 2'h2;

    // ========================================================================
    // short word layout
    localparam int          W0_LEN_LSB     = 0;
    localparam int          W0_END_LSB     = 16;
    localparam int          W0_RING_BIT    = 27;
    localparam int          W0_OK_BIT      = 28;
    localparam int          W0_ID_LSB      = 30;
    localparam logic [1:0]  COMP_ID        = 2'h1;

    // ========================================================================
    // engine states
    typedef enum logic [5:0] {
        RXQ_IDLE   = 6'h01,
        RXQ_FETCH  = 6'h02,
        RXQ_HIGH   = 6'h04,
        RXQ_HAND   = 6'h08,
        RXQ_XFER   = 6'h10,
        RXQ_CWRITE = 6'h20
    } rxq_state_t;

endpackage : rxq_pkg

//--- hdl/rxq_dma.sv
// receive descriptor queue engine: buffer fetch, sorting and completion writes
// What this block does
// - one completion entry per fully transferred frame
// - completion ring 1024 entries, base from control
// - format 00b writes one short word
// - format 01b adds status and vlan word
// - format 10b adds status and checksum word
// - format 11b writes four words incl timestamp
// - entry covers consecutive buffers the frame needed
// - two completion rings routed by sort criterion
// - width bit selects 32 or 64-bit descriptors
// - buffer ring depth 256 or 2048 entries
// - completion and buffer ring counts independent
// - single completion, two buffer rings: ring bit
// - two buffer rings chosen by sort criterion
// - device produces entries, software writes consumer index
// - polling ignores producer, waits for valid bit
// - when polling, end bit marks final descriptor of list
// - completion handling identical in both models
// - second ring buffer length is size threshold
module rxq_dma #(
    parameter int LEN_W = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    output logic      [31:0]      reg_rdata,
    input  wire logic             frame_valid,
    output logic                  frame_ready,
    input  wire logic [LEN_W-1:0] frame_len,
    input  wire logic [11:0]      frame_vlan_id,
    input  wire logic [2:0]       frame_vlan_prio,
    input  wire logic             frame_filter_prio,
    input  wire logic [15:0]      frame_csum,
    input  wire logic [15:0]      frame_ext_status,
    input  wire logic [31:0]      frame_timestamp,
    input  wire logic             frame_done,
    output logic                  buf_valid,
    input  wire logic             buf_ready,
    output logic      [63:0]      buf_addr,
    output logic                  buf_ring,
    output logic                  mem_req,
    output logic                  mem_we,
    output logic      [63:0]      mem_addr,
    output logic      [31:0]      mem_wdata,
    input  wire logic             mem_ack,
    input  wire logic [31:0]      mem_rdata
);

    // ========================================================================
    // helpers
    function automatic logic [10:0] rxq_next_bidx(input logic [10:0] idx,
                                                  input logic [10:0] last);
        return (idx == last) ? 11'h000 : idx + 11'h001;
    endfunction : rxq_next_bidx

    function automatic logic [2:0] rxq_entry_words(input logic [1:0] fmt);
        case (fmt)
            rxq_pkg::FMT_SHORT: return 3'h1;
            rxq_pkg::FMT_FULL:  return 3'h4;
            default:            return 3'h2;
        endcase
    endfunction : rxq_entry_words

    // ========================================================================
    // register storage
    logic [31:0] cq_ctrl [2], bq_ctrl [2], bq_base [2];
    logic [31:0] dma_ctrl;
    logic [10:0] bq_prod [2], bq_cons [2];
    logic [9:0]  cq_cons [2], cq_prod [2];

    // engine state and latched frame
    rxq_pkg::rxq_state_t state;
    logic [LEN_W-1:0] len_q, rem_q;
    logic [11:0]      vid_q;
    logic [2:0]       prio_q;
    logic [15:0]      csum_q, ext_q;
    logic [31:0]      ts_q;
    logic             bsel, csel, first_q, end_bit_q;
    logic [10:0]      start_idx, end_idx;
    logic [2:0]       wcnt;

    // decoded configuration
    logic             polling, wide, bq2_en, cq2_en;
    logic [10:0]      bq_last;
    logic [1:0]       sort_mode, fmt;
    logic [2:0]       words;
    logic [LEN_W-1:0] blen;
    logic             sort_hi, avail, cq_full, mem_done, rd_need, wr_need;
    logic [63:0]      desc_addr, comp_addr;
    logic [31:0]      comp_word, next_rdata;

    // ring 1 control carries mode, depth and width for both buffer rings
    assign polling   = bq_ctrl[0][rxq_pkg::BQ_POLL_BIT];
    assign wide      = bq_ctrl[0][rxq_pkg::BQ_WIDE_BIT];
    assign bq_last   = bq_ctrl[0][rxq_pkg::BQ_DEPTH_BIT] ? rxq_pkg::BQ_LAST_LARGE
                                                         : rxq_pkg::BQ_LAST_SMALL;
    assign bq2_en    = bq_ctrl[1][rxq_pkg::BQ2_EN_BIT];
    assign cq2_en    = dma_ctrl[rxq_pkg::DMA_CQ2_EN_BIT];
    assign sort_mode = dma_ctrl[rxq_pkg::DMA_SORT_LSB +: 2];
    assign fmt       = cq_ctrl[csel][rxq_pkg::CQ_FMT_LSB +: 2];
    assign words     = rxq_entry_words(fmt);
    assign blen      = bq_ctrl[bsel][rxq_pkg::BQ_LEN_LSB +: LEN_W];
    assign mem_done  = mem_req & mem_ack;

    // sort decision on the arriving frame
    always_comb begin
        case (sort_mode)
            rxq_pkg::SORT_SIZE: sort_hi = frame_len <= bq_ctrl[1][rxq_pkg::BQ_LEN_LSB +: LEN_W];
            rxq_pkg::SORT_VLAN: sort_hi = frame_vlan_prio[2];
            default:            sort_hi = frame_filter_prio;
        endcase
    end

    // buffer availability: producer index only counts in the index model
    assign avail   = polling | (bq_cons[bsel] != bq_prod[bsel]);
    assign cq_full = (cq_prod[csel] + 10'h001) == cq_cons[csel];

    // ========================================================================
    // register writes from software
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cq_ctrl[0] <= rxq_pkg::REG_RESET;
            cq_ctrl[1] <= rxq_pkg::REG_RESET;
            bq_ctrl[0] <= rxq_pkg::REG_RESET;
            bq_ctrl[1] <= rxq_pkg::REG_RESET;
            bq_base[0] <= rxq_pkg::REG_RESET;
            bq_base[1] <= rxq_pkg::REG_RESET;
            dma_ctrl   <= rxq_pkg::REG_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                rxq_pkg::OFF_CQ1_CTRL: cq_ctrl[0] <= reg_wdata;
                rxq_pkg::OFF_CQ2_CTRL: cq_ctrl[1] <= reg_wdata;
                rxq_pkg::OFF_DMA_CTRL: dma_ctrl   <= reg_wdata;
                rxq_pkg::OFF_BQ1_CTRL: bq_ctrl[0] <= reg_wdata;
                rxq_pkg::OFF_BQ2_CTRL: bq_ctrl[1] <= reg_wdata;
                rxq_pkg::OFF_BQ1_BASE: bq_base[0] <= reg_wdata;
                rxq_pkg::OFF_BQ2_BASE: bq_base[1] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // software-owned indices: buffer producers, completion consumers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bq_prod[0] <= '0;
            bq_prod[1] <= '0;
            cq_cons[0] <= '0;
            cq_cons[1] <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                rxq_pkg::OFF_BQ1_PTRS: bq_prod[0] <= reg_wdata[rxq_pkg::PTR_PROD_LSB +: 11];
                rxq_pkg::OFF_BQ2_PTRS: bq_prod[1] <= reg_wdata[rxq_pkg::PTR_PROD_LSB +: 11];
                rxq_pkg::OFF_CQ1_CONS: cq_cons[0] <= reg_wdata[rxq_pkg::PTR_PROD_LSB +: 10];
                rxq_pkg::OFF_CQ2_PTRS: cq_cons[1] <= reg_wdata[rxq_pkg::PTR_PROD_LSB +: 10];
                default: ;
            endcase
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        next_rdata = rxq_pkg::REG_RESET;
        case (reg_addr)
            rxq_pkg::OFF_CQ1_CTRL: next_rdata = cq_ctrl[0];
            rxq_pkg::OFF_CQ2_CTRL: next_rdata = cq_ctrl[1];
            rxq_pkg::OFF_DMA_CTRL: next_rdata = dma_ctrl;
            rxq_pkg::OFF_BQ1_CTRL: next_rdata = bq_ctrl[0];
            rxq_pkg::OFF_BQ2_CTRL: next_rdata = bq_ctrl[1];
            rxq_pkg::OFF_BQ1_BASE: next_rdata = bq_base[0];
            rxq_pkg::OFF_BQ2_BASE: next_rdata = bq_base[1];
            rxq_pkg::OFF_CQ1_CONS: next_rdata[rxq_pkg::PTR_PROD_LSB +: 10] = cq_cons[0];
            rxq_pkg::OFF_CQ1_PROD: next_rdata[rxq_pkg::PTR_PROD_LSB +: 10] = cq_prod[0];
            rxq_pkg::OFF_CQ2_PTRS: begin
                next_rdata[rxq_pkg::PTR_PROD_LSB +: 10] = cq_cons[1];
                next_rdata[rxq_pkg::PTR_CONS_LSB +: 10] = cq_prod[1];
            end
            rxq_pkg::OFF_BQ1_PTRS: begin
                next_rdata[rxq_pkg::PTR_PROD_LSB +: 11] = bq_prod[0];
                next_rdata[rxq_pkg::PTR_CONS_LSB +: 11] = bq_cons[0];
            end
            rxq_pkg::OFF_BQ2_PTRS: begin
                next_rdata[rxq_pkg::PTR_PROD_LSB +: 11] = bq_prod[1];
                next_rdata[rxq_pkg::PTR_CONS_LSB +: 11] = bq_cons[1];
            end
            default: ;
        endcase
    end

    // read data registered, valid the cycle after reg_rd
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= rxq_pkg::REG_RESET;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ========================================================================
    // host memory addresses
    always_comb begin
        desc_addr = 64'(bq_base[bsel]) + (64'(bq_cons[bsel]) << (wide ? 3'h3 : 3'h2));
        if (state == rxq_pkg::RXQ_HIGH) begin
            desc_addr = desc_addr + (64'h1 << rxq_pkg::WORD_SHIFT);
        end
        comp_addr = 64'(cq_ctrl[csel] & rxq_pkg::CQ_BASE_MASK)
                  + ((64'(cq_prod[csel]) * 64'(words) + 64'(wcnt)) << rxq_pkg::WORD_SHIFT);
    end

    // completion word for the current word slot
    always_comb begin
        comp_word = '0;
        case (wcnt)
            3'h0: begin
                comp_word[rxq_pkg::W0_LEN_LSB +: 16] = 16'(len_q);
                comp_word[rxq_pkg::W0_END_LSB +: 11] = end_idx;
                comp_word[rxq_pkg::W0_RING_BIT]      = ~cq2_en & bq2_en & bsel;
                comp_word[rxq_pkg::W0_OK_BIT]        = 1'b1;
                comp_word[rxq_pkg::W0_ID_LSB +: 2]   = rxq_pkg::COMP_ID;
            end
            3'h1: begin
                case (fmt)
                    rxq_pkg::FMT_BASIC: comp_word = {ext_q, 1'b0, prio_q, vid_q};
                    rxq_pkg::FMT_CSUM:  comp_word = {ext_q, csum_q};
                    default:            comp_word = {ext_q, 5'h00, start_idx};
                endcase
            end
            3'h2: comp_word = {1'b0, prio_q, vid_q, csum_q};
            default: comp_word = ts_q;
        endcase
    end

    // ========================================================================
    // memory port: one request outstanding, held until acknowledged
    assign rd_need = (state == rxq_pkg::RXQ_FETCH && avail) || state == rxq_pkg::RXQ_HIGH;
    assign wr_need = state == rxq_pkg::RXQ_CWRITE && !(wcnt == 3'h0 && cq_full);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= '0;
            mem_wdata <= '0;
        end else if (mem_req) begin
            if (mem_ack) begin
                mem_req <= 1'b0;
            end
        end else if (rd_need) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= desc_addr;
        end else if (wr_need) begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_addr  <= comp_addr;
            mem_wdata <= comp_word;
        end
    end

    // ========================================================================
    // frame sequencing
    assign frame_ready = state == rxq_pkg::RXQ_IDLE;
    assign buf_valid   = state == rxq_pkg::RXQ_HAND;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= rxq_pkg::RXQ_IDLE;
            len_q     <= '0;
            rem_q     <= '0;
            vid_q     <= '0;
            prio_q    <= '0;
            csum_q    <= '0;
            ext_q     <= '0;
            ts_q      <= '0;
            bsel      <= 1'b0;
            csel      <= 1'b0;
            first_q   <= 1'b0;
            end_bit_q <= 1'b0;
            start_idx <= '0;
            end_idx   <= '0;
            wcnt      <= '0;
            buf_addr  <= '0;
            buf_ring  <= 1'b0;
            bq_cons[0] <= '0;
            bq_cons[1] <= '0;
            cq_prod[0] <= '0;
            cq_prod[1] <= '0;
        end else begin
            case (state)
                rxq_pkg::RXQ_IDLE: begin
                    if (frame_valid) begin
                        len_q   <= frame_len;
                        rem_q   <= frame_len;
                        vid_q   <= frame_vlan_id;
                        prio_q  <= frame_vlan_prio;
                        csum_q  <= frame_csum;
                        ext_q   <= frame_ext_status;
                        ts_q    <= frame_timestamp;
                        bsel    <= bq2_en & sort_hi;
                        csel    <= cq2_en & sort_hi;
                        first_q <= 1'b1;
                        state   <= rxq_pkg::RXQ_FETCH;
                    end
                end
                rxq_pkg::RXQ_FETCH: begin
                    // when polling, an invalid descriptor is simply polled again
                    if (mem_done && (!polling || mem_rdata[rxq_pkg::DESC_VALID_BIT])) begin
                        buf_addr  <= {32'h0000_0000, mem_rdata & rxq_pkg::DESC_ADDR_MASK};
                        end_bit_q <= polling & mem_rdata[rxq_pkg::DESC_END_BIT];
                        state     <= wide ? rxq_pkg::RXQ_HIGH : rxq_pkg::RXQ_HAND;
                    end
                end
                rxq_pkg::RXQ_HIGH: begin
                    if (mem_done) begin
                        buf_addr[63:32] <= mem_rdata;
                        state           <= rxq_pkg::RXQ_HAND;
                    end
                end
                rxq_pkg::RXQ_HAND: begin
                    buf_ring <= bsel;
                    if (buf_ready) begin
                        first_q <= 1'b0;
                        end_idx <= bq_cons[bsel];
                        if (first_q) begin
                            start_idx <= bq_cons[bsel];
                        end
                        // end descriptor or last entry returns the ring to zero
                        bq_cons[bsel] <= end_bit_q ? '0 : rxq_next_bidx(bq_cons[bsel], bq_last);
                        if (rem_q <= blen) begin
                            state <= rxq_pkg::RXQ_XFER;
                        end else begin
                            rem_q <= rem_q - blen;
                            state <= rxq_pkg::RXQ_FETCH;
                        end
                    end
                end
                rxq_pkg::RXQ_XFER: begin
                    if (frame_done) begin
                        wcnt  <= '0;
                        state <= rxq_pkg::RXQ_CWRITE;
                    end
                end
                rxq_pkg::RXQ_CWRITE: begin
                    if (mem_done) begin
                        if (wcnt + 3'h1 == words) begin
                            cq_prod[csel] <= (cq_prod[csel] == rxq_pkg::CQ_LAST) ? '0
                                           : cq_prod[csel] + 10'h001;
                            state         <= rxq_pkg::RXQ_IDLE;
                        end else begin
                            wcnt <= wcnt + 3'h1;
                        end
                    end
                end
                default: state <= rxq_pkg::RXQ_IDLE;
            endcase
        end
    end

endmodule : rxq_dma

//--- verif/rxq_dma_asserts.sv
// port checker of the receive descriptor queue engine
module rxq_dma_asserts (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        frame_valid,
    input wire logic        frame_ready,
    input wire logic        frame_done,
    input wire logic        buf_valid,
    input wire logic        buf_ready,
    input wire logic [63:0] buf_addr,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [63:0] mem_addr,
    input wire logic        mem_ack
);
    // ========================================================================
    // frame, buffer and memory handshakes
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    property p_frame_busy; frame_valid && frame_ready |=> !frame_ready; endproperty
    a_frame_busy: assert property (p_frame_busy) else $error("frame taken, still ready");
    property p_ready_back; $rose(frame_ready) |-> $past(mem_ack && mem_we); endproperty
    a_ready_back: assert property (p_ready_back) else $error("idle without final write");
    property p_done_write; frame_done |-> ##[1:60] (mem_req && mem_we); endproperty
    a_done_write: assert property (p_done_write) else $error("no completion write");
    property p_cq_addr; mem_req && mem_we |-> mem_addr[1:0] == 2'h0; endproperty
    a_cq_addr: assert property (p_cq_addr) else $error("completion word misaligned");
    property p_req_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped early");
    property p_req_free; mem_req && mem_ack |=> !mem_req; endproperty
    a_req_free: assert property (p_req_free) else $error("request held after ack");
    property p_buf_hold; buf_valid && $past(buf_valid) && !buf_ready |=> $stable(buf_addr); endproperty
    a_buf_hold: assert property (p_buf_hold) else $error("buffer address moved");
    property p_idle_no_buf; frame_ready |-> !buf_valid; endproperty
    a_idle_no_buf: assert property (p_idle_no_buf) else $error("buffer offered while idle");
    c_frame: cover property (frame_valid && frame_ready);
    c_buf: cover property (buf_valid && buf_ready);
    c_write: cover property (mem_req && mem_we && mem_ack);
endmodule : rxq_dma_asserts
bind rxq_dma rxq_dma_asserts u_chk (.ref_clk, .rst_n, .frame_valid, .frame_ready, .frame_done,
    .buf_valid, .buf_ready, .buf_addr, .mem_req, .mem_we, .mem_addr, .mem_ack);

//--- verif/rxq_host_mem.sv
// host memory model holding descriptor and completion rings
module rxq_host_mem (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [63:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic             mem_ack,
    output logic      [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [logic [63:0]];
    logic [1:0]  dly;
    // ========================================================================
    // one answer per request, prompt or stalled
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {mem_ack, mem_rdata, dly} <= '0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;   // no stale data between answers
            if (mem_req && !mem_ack && dly != 2'h0) begin
                dly <= dly - 2'h1;
            end else if (mem_req && !mem_ack) begin
                mem_ack <= 1'b1;
                dly <= slow ? 2'h3 : 2'h0;
                if (mem_we) mem[mem_addr] = mem_wdata;
                // unwritten descriptors: valid set, end clear
                mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : {mem_addr[29:0], 2'b01};
            end
        end
    end
endmodule : rxq_host_mem

//--- verif/rx_descriptor_queue_dma_tb.sv
// self-checking bench of the receive descriptor queue engine
module rx_descriptor_queue_dma_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rst_n, reg_wr, reg_rd, frame_valid, frame_filter_prio, frame_done;
    logic        buf_ready, slow, frame_ready, buf_valid, buf_ring, mem_req, mem_we, mem_ack, rg;
    logic        wide, poll;
    logic [1:0]  fm;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, frame_timestamp, mem_wdata, mem_rdata, d, e;
    logic [15:0] frame_len, frame_csum, frame_ext_status;
    logic [11:0] frame_vlan_id;
    logic [2:0]  frame_vlan_prio;
    logic [63:0] buf_addr, mem_addr;
    logic [10:0] cons [2];
    logic [10:0] st;
    int          mismatches, num_checks, n, nw, cnt, k, ln, bl;
    rxq_dma dut (.*);
    rxq_host_mem host (.*);
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        check(64'(reg_rdata), 64'(v));
    endtask : rd
    // expected completion word from the frame just sent
    function automatic logic [31:0] ew(input int w);
        logic [10:0] ei;
        ei = (st + 11'(n) - 11'h1) & 11'h0ff;
        case (w)
            0: return {2'h1, 1'b0, 1'b1, rg, ei, frame_len};
            1: return fm == 2'h1 ? {frame_ext_status, 1'b0, frame_vlan_prio, frame_vlan_id}
                : fm == 2'h2 ? {frame_ext_status, frame_csum} : {frame_ext_status, 5'h0, st};
            2: return {1'b0, frame_vlan_prio, frame_vlan_id, frame_csum};
            default: return frame_timestamp;
        endcase
    endfunction : ew
    // ========================================================================
    // main sequence
    initial begin
        {rst_n, reg_wr, reg_rd, frame_valid, frame_filter_prio, frame_done, buf_ready, slow} = '0;
        {reg_addr, reg_wdata, frame_timestamp, frame_len, frame_csum} = '0;
        {frame_ext_status, frame_vlan_id, frame_vlan_prio, mismatches, num_checks, k} = '0;
        cons = '{default: 11'h0};
        void'($urandom(60210));
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(rxq_pkg::OFF_BQ1_PTRS, rxq_pkg::REG_RESET);
        rd(8'h00, 32'h0000_0000);
        wr(rxq_pkg::OFF_CQ1_PROD, 32'h0000_0155);
        rd(rxq_pkg::OFF_CQ1_PROD, 32'h0000_0000);
        wr(rxq_pkg::OFF_DMA_CTRL, 32'h0000_0004);   // sort by size
        wr(rxq_pkg::OFF_BQ2_CTRL, 32'h0001_0080);   // ring2 on, 128 bytes
        wr(rxq_pkg::OFF_BQ1_BASE, 32'h0002_0000);
        wr(rxq_pkg::OFF_BQ2_BASE, 32'h0003_0000);
        for (int f = 0; f < 24; f++) begin
            fm = 2'(f);
            wide = (f % 3 == 1);
            poll = (f % 4 == 2);   // polling model, producer left behind
            ln = f == 0 ? 128 : f == 1 ? 129 : f == 2 ? 32 : 1 + $urandom % 1000;
            rg = ln <= 128;
            bl = rg ? 128 : 32;
            n = (ln + bl - 1) / bl;
            st = cons[rg];
            wr(rxq_pkg::OFF_CQ1_CTRL, 32'h0001_0000 | 32'(fm));
            wr(rxq_pkg::OFF_BQ1_CTRL, {13'h0, wide, 1'b0, poll, 16'h0020});
            @(posedge ref_clk);
            {frame_valid, frame_len, frame_timestamp, slow} <= {1'b1, 16'(ln), $urandom, 1'($urandom)};
            {frame_vlan_id, frame_vlan_prio, frame_filter_prio, frame_csum, frame_ext_status}
                <= 48'({$urandom, $urandom});
            @(posedge ref_clk);
            frame_valid <= 1'b0;
            repeat (8) @(negedge ref_clk);
            if (!poll) check(64'(buf_valid), 64'h0);
            wr(rg ? rxq_pkg::OFF_BQ2_PTRS : rxq_pkg::OFF_BQ1_PTRS, 32'((st + 11'(n)) & 11'h0ff));
            cnt = 0;
            for (int i = 0; i < 3000 && cnt < n; i++) begin
                @(negedge ref_clk);
                if (buf_valid && buf_ready) begin
                    d = (rg ? 32'h0003_0000 : 32'h0002_0000) + 32'((st + 11'(cnt)) & 11'h0ff) * (wide ? 8 : 4);
                    e = d + 32'h0000_0004;
                    check(64'(buf_ring), 64'(rg));
                    check(buf_addr, {wide ? {e[29:0], 2'b01} : 32'h0, d[29:0], 2'b00});
                    cnt++;
                end
                @(posedge ref_clk);
                buf_ready <= buf_valid & 1'($urandom);
            end
            if (cnt != n) begin
                mismatches++;
                tally_and_finish();
            end
            @(posedge ref_clk);
            {frame_done, buf_ready} <= 2'b10;
            @(posedge ref_clk);
            frame_done <= 1'b0;
            for (int i = 0; i < 4000 && frame_ready !== 1'b1; i++) @(negedge ref_clk);
            check(64'(frame_ready), 64'h1);
            if (frame_ready !== 1'b1) tally_and_finish();
            cons[rg] = (st + 11'(n)) & 11'h0ff;
            nw = fm == 2'h0 ? 1 : fm == 2'h3 ? 4 : 2;
            for (int w = 0; w < nw; w++) begin
                check(64'(host.mem[64'(32'h0001_0000 + (k * nw + w) * 4)]), 64'(ew(w)));
            end
            k++;
        end
        rd(rxq_pkg::OFF_CQ1_PROD, 32'(k));
        rd(rxq_pkg::OFF_BQ1_PTRS, {5'h0, cons[0], 5'h0, cons[0]});
        tally_and_finish();
    end
endmodule : rx_descriptor_queue_dma_tb
